// ### hw/accel_pkg.sv
// Constants shared by the arithmetic accelerator, its bound checker and its testbench.
// Assumes an 8-bit special function register bus on the core clock.
package accel_pkg;
	// ==========================================================
	// Register addresses
	localparam logic [7:0] ctl0_addr = 8'hD1;
	localparam logic [7:0] ctl1_addr = 8'hD2;
	localparam logic [7:0] opa_addr  = 8'hD3;
	localparam logic [7:0] opb_addr  = 8'hD4;
	localparam logic [7:0] acc_addr  = 8'hD5;
	localparam logic [7:0] cmd_addr  = 8'hD6;
	// ==========================================================
	// Field positions
	localparam int dir_bit   = 7;
	localparam int circ_bit  = 6;
	localparam int cen_bit   = 5;
	localparam int busy_bit  = 7;
	localparam int ovf_bit   = 6;
	localparam int carry_bit = 5;
	localparam int clear_bit = 4;
	localparam logic [3:0] ctl1_reserved = 4'hF;
	// ==========================================================
	// Reset values
	localparam logic [7:0]  ctl0_rst = 8'h00;
	localparam logic [31:0] opa_rst  = 32'h0000_0000;
	localparam logic [15:0] opb_rst  = 16'h0000;
	localparam logic [39:0] acc_rst  = 40'h00_0000_0000;
	localparam logic [7:0]  rdata_rst = 8'h00;
	// ==========================================================
	// Counts and limits
	localparam logic [2:0]  acc_last_byte = 3'h4;
	localparam logic [2:0]  zero_writes   = 3'h5;
	localparam logic [4:0]  norm_limit    = 5'h1F;
	localparam logic [31:0] result_max    = 32'h0000_FFFF;
	localparam int          div_steps     = 32;
	// ==========================================================
	// Operation codes written to the command register
	localparam logic [1:0] op_mul   = 2'h0;
	localparam logic [1:0] op_div   = 2'h1;
	localparam logic [1:0] op_shift = 2'h2;
endpackage

// ### hw/shift_step.sv
// One-position shift of the 32-bit value with circular and carry options.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ns
module shift_step
(
	input  wire logic [31:0] val,
	input  wire logic        carry_in,
	input  wire logic        left,
	input  wire logic        circ,
	input  wire logic        carry_en,
	output logic      [31:0] val_out,
	output logic             carry_out
);
	// ==========================================================
	// Shift
	// Carry shifting takes precedence when both options are set,
	// making a 33-bit rotate through the carry.
	always_comb
	begin
		val_out   = 32'h0000_0000;
		carry_out = carry_in;
		if (left)
		begin
			if (carry_en)
			begin
				val_out   = {val[30:0], carry_in};
				carry_out = val[31];
			end
			else if (circ)
				val_out = {val[30:0], val[31]};
			else
				val_out = {val[30:0], 1'b0};
		end
		else
		begin
			if (carry_en)
			begin
				val_out   = {carry_in, val[31:1]};
				carry_out = val[0];
			end
			else if (circ)
				val_out = {val[0], val[31:1]};
			else
				val_out = {1'b0, val[31:1]};
		end
	end
endmodule

// ### hw/divide_unit.sv
// Restoring divider, one quotient bit per clock.
// Start is a one-cycle pulse; done pulses once when the results stand.
`timescale 1ns/1ns
module divide_unit
#(
	parameter int N = 32,
	parameter int D = 16
)
(
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic         start,
	input  wire logic         abort,
	input  wire logic [N-1:0] dividend,
	input  wire logic [D-1:0] divisor,
	output logic              done,
	output logic      [N-1:0] quotient,
	output logic      [D-1:0] remainder
);
	localparam int CW = $clog2(N);
	localparam logic [CW-1:0] last = CW'(N - 1);

	logic [N-1:0]  quo_r, quo_nxt;
	logic [D-1:0]  rem_r, rem_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic          run_r, run_nxt;
	logic          done_r, done_nxt;
	logic [D:0]    trial;

	// ==========================================================
	// Next state
	always_comb
	begin
		quo_nxt  = quo_r;
		rem_nxt  = rem_r;
		cnt_nxt  = cnt_r;
		run_nxt  = run_r;
		done_nxt = 1'b0;
		trial    = {rem_r, quo_r[N-1]};
		if (start)
		begin
			quo_nxt = dividend;
			rem_nxt = '0;
			cnt_nxt = '0;
			run_nxt = 1'b1;
		end
		else if (run_r)
		begin
			if (trial >= {1'b0, divisor})
			begin
				rem_nxt = D'(trial - {1'b0, divisor});
				quo_nxt = {quo_r[N-2:0], 1'b1};
			end
			else
			begin
				rem_nxt = trial[D-1:0];
				quo_nxt = {quo_r[N-2:0], 1'b0};
			end
			cnt_nxt = cnt_r + 1'b1;
			if (cnt_r == last)
			begin
				run_nxt  = 1'b0;
				done_nxt = 1'b1;
			end
		end
		if (abort)
		begin
			run_nxt  = 1'b0;
			done_nxt = 1'b0;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			quo_r  <= '0;
			rem_r  <= '0;
			cnt_r  <= '0;
			run_r  <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			quo_r  <= quo_nxt;
			rem_r  <= rem_nxt;
			cnt_r  <= cnt_nxt;
			run_r  <= run_nxt;
			done_r <= done_nxt;
		end
	end

	assign done      = done_r;
	assign quotient  = quo_r;
	assign remainder = rem_r;
endmodule

// ### hw/arith_accel.sv
// Multiply, divide, shift and normalize accelerator beside the processor core.
// Assumes single-cycle register bus strobes on clk; read data follows a cycle later.
`timescale 1ns/1ns
module arith_accel
(
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata
);
	typedef enum logic [2:0] {st_idle, st_load, st_shift, st_norm, st_div} state_t;

	// ==========================================================
	// State
	state_t      state_r, state_nxt;
	logic        dir_r, dir_nxt;
	logic        circ_r, circ_nxt;
	logic        cen_r, cen_nxt;
	logic [4:0]  cnt_r, cnt_nxt;
	logic        busy_r, busy_nxt;
	logic        ovf_r, ovf_nxt;
	logic        carry_r, carry_nxt;
	logic [31:0] opa_r, opa_nxt;
	logic [15:0] opb_r, opb_nxt;
	logic [39:0] acc_r, acc_nxt;
	logic [1:0]  pa_r, pa_nxt;
	logic        pb_r, pb_nxt;
	logic [2:0]  accw_r, accw_nxt;
	logic [2:0]  accr_r, accr_nxt;
	logic [2:0]  zcnt_r, zcnt_nxt;
	logic [4:0]  steps_r, steps_nxt;
	logic [7:0]  rdata_r, rdata_nxt;

	logic        wr_c0, wr_c1, wr_a, wr_b, wr_acc, wr_cmd;
	logic        init, div_start;
	logic [31:0] sh_val;
	logic        sh_carry;
	logic        div_done;
	logic [31:0] div_quo;
	logic [15:0] div_rem;
	logic [31:0] prod;
	logic        can_load;

	assign wr_c0  = sfr_wr && (sfr_addr == accel_pkg::ctl0_addr);
	assign wr_c1  = sfr_wr && (sfr_addr == accel_pkg::ctl1_addr);
	assign wr_a   = sfr_wr && (sfr_addr == accel_pkg::opa_addr);
	assign wr_b   = sfr_wr && (sfr_addr == accel_pkg::opb_addr);
	assign wr_acc = sfr_wr && (sfr_addr == accel_pkg::acc_addr);
	assign wr_cmd = sfr_wr && (sfr_addr == accel_pkg::cmd_addr);
	assign prod   = opa_r[15:0] * opb_r;
	assign can_load = (state_r == st_idle) || (state_r == st_load);

	// ==========================================================
	// Datapath helpers
	shift_step u_shift
	(
		.val       (opa_r),
		.carry_in  (carry_r),
		.left      (!dir_r),
		.circ      (circ_r),
		.carry_en  (cen_r),
		.val_out   (sh_val),
		.carry_out (sh_carry)
	);

	divide_unit #(.N(32), .D(16)) u_div
	(
		.clk       (clk),
		.srst      (srst),
		.start     (div_start),
		.abort     (init),
		.dividend  (opa_r),
		.divisor   (opb_r),
		.done      (div_done),
		.quotient  (div_quo),
		.remainder (div_rem)
	);

	// ==========================================================
	// Next state
	always_comb
	begin
		state_nxt = state_r;
		dir_nxt   = dir_r;
		circ_nxt  = circ_r;
		cen_nxt   = cen_r;
		cnt_nxt   = cnt_r;
		busy_nxt  = busy_r;
		ovf_nxt   = ovf_r;
		carry_nxt = carry_r;
		opa_nxt   = opa_r;
		opb_nxt   = opb_r;
		acc_nxt   = acc_r;
		pa_nxt    = pa_r;
		pb_nxt    = pb_r;
		accw_nxt  = accw_r;
		accr_nxt  = accr_r;
		zcnt_nxt  = zcnt_r;
		steps_nxt = steps_r;
		rdata_nxt = rdata_r;
		init      = 1'b0;
		div_start = 1'b0;

		// Register reads; reads of the data ports advance their byte pointers.
		if (sfr_rd)
		begin
			unique case (sfr_addr)
				accel_pkg::ctl0_addr: rdata_nxt = {dir_r, circ_r, cen_r, cnt_r};
				accel_pkg::ctl1_addr: rdata_nxt = {busy_r, ovf_r, carry_r, 1'b0, accel_pkg::ctl1_reserved};
				accel_pkg::opa_addr:
				begin
					rdata_nxt = opa_r[{pa_r, 3'b000} +: 8];
					pa_nxt    = pa_r + 1'b1;
				end
				accel_pkg::opb_addr:
				begin
					rdata_nxt = opb_r[{pb_r, 3'b000} +: 8];
					pb_nxt    = !pb_r;
				end
				accel_pkg::acc_addr:
				begin
					rdata_nxt = acc_r[{accr_r, 3'b000} +: 8];
					accr_nxt  = (accr_r == 3'h0) ? accel_pkg::acc_last_byte : accr_r - 1'b1;
				end
				default: rdata_nxt = 8'h00;
			endcase
		end

		if (wr_c0)
		begin
			dir_nxt  = sfr_wdata[accel_pkg::dir_bit];
			circ_nxt = sfr_wdata[accel_pkg::circ_bit];
			cen_nxt  = sfr_wdata[accel_pkg::cen_bit];
			cnt_nxt  = sfr_wdata[4:0];
		end

		// Operand loading; the first byte into an idle accelerator raises busy.
		if (wr_a && can_load)
		begin
			opa_nxt[{pa_r, 3'b000} +: 8] = sfr_wdata;
			pa_nxt = pa_r + 1'b1;
		end
		if (wr_b && can_load)
		begin
			opb_nxt[{pb_r, 3'b000} +: 8] = sfr_wdata;
			pb_nxt = !pb_r;
		end
		if ((wr_a || wr_b) && (state_r == st_idle))
		begin
			busy_nxt  = 1'b1;
			state_nxt = st_load;
		end

		// ======================================================
		// Operation sequencing
		unique case (state_r)
			st_idle:
			begin
			end
			st_load:
			begin
				if (wr_cmd)
				begin
					unique case (sfr_wdata[1:0])
						accel_pkg::op_mul:
						begin
							opa_nxt   = prod;
							acc_nxt   = acc_r + {8'h00, prod};
							ovf_nxt   = ovf_r || (prod > accel_pkg::result_max);
							busy_nxt  = 1'b0;
							state_nxt = st_idle;
							pa_nxt    = 2'h0;
							pb_nxt    = 1'b0;
						end
						accel_pkg::op_div:
						begin
							div_start = 1'b1;
							state_nxt = st_div;
						end
						accel_pkg::op_shift:
						begin
							steps_nxt = (cnt_r == 5'h00) ? 5'h00 : cnt_r;
							state_nxt = (cnt_r == 5'h00) ? st_norm : st_shift;
						end
						default:
						begin
						end
					endcase
				end
			end
			st_shift:
			begin
				opa_nxt   = sh_val;
				carry_nxt = cen_r ? sh_carry : carry_r;
				steps_nxt = steps_r - 1'b1;
				if (steps_r == 5'h01)
				begin
					busy_nxt  = 1'b0;
					state_nxt = st_idle;
					pa_nxt    = 2'h0;
				end
			end
			st_norm:
			begin
				// Normalizing stops at a set top bit, a zero value, or the field's limit.
				if (opa_r[31] || (opa_r == 32'h0000_0000) || (steps_r == accel_pkg::norm_limit))
				begin
					cnt_nxt   = steps_r;
					busy_nxt  = 1'b0;
					state_nxt = st_idle;
					pa_nxt    = 2'h0;
				end
				else
				begin
					opa_nxt   = {opa_r[30:0], 1'b0};
					steps_nxt = steps_r + 1'b1;
				end
			end
			st_div:
			begin
				if (div_done)
				begin
					opa_nxt   = div_quo;
					opb_nxt   = div_rem;
					acc_nxt   = acc_r + {8'h00, div_quo};
					ovf_nxt   = ovf_r || (opb_r == 16'h0000) || (div_quo > accel_pkg::result_max);
					busy_nxt  = 1'b0;
					state_nxt = st_idle;
					pa_nxt    = 2'h0;
					pb_nxt    = 1'b0;
				end
			end
			default:
			begin
				state_nxt = st_idle;
			end
		endcase

		// ======================================================
		// Accumulator port writes
		if (wr_acc)
		begin
			acc_nxt[{accw_r, 3'b000} +: 8] = sfr_wdata;
			accw_nxt = (accw_r == accel_pkg::acc_last_byte) ? 3'h0 : accw_r + 1'b1;
			zcnt_nxt = (sfr_wdata == 8'h00) ? zcnt_r + 1'b1 : 3'h0;
			if ((sfr_wdata == 8'h00) && (zcnt_r == accel_pkg::zero_writes - 3'h1))
			begin
				acc_nxt  = accel_pkg::acc_rst;
				zcnt_nxt = 3'h0;
				accw_nxt = 3'h0;
			end
		end

		// ======================================================
		// Control one writes; a software write wins over the engine's carry update.
		if (wr_c1)
		begin
			carry_nxt = sfr_wdata[accel_pkg::carry_bit];
			if (busy_r && !sfr_wdata[accel_pkg::busy_bit])
				init = 1'b1;
			if (sfr_wdata[accel_pkg::busy_bit])
				acc_nxt = accel_pkg::acc_rst;
			if (sfr_wdata[accel_pkg::clear_bit])
			begin
				opa_nxt = accel_pkg::opa_rst;
				opb_nxt = accel_pkg::opb_rst;
				acc_nxt = accel_pkg::acc_rst;
			end
		end

		// Initialization leaves the block ready for fresh operands.
		if (init)
		begin
			state_nxt = st_idle;
			busy_nxt  = 1'b0;
			cnt_nxt   = 5'h00;
			ovf_nxt   = 1'b0;
			steps_nxt = 5'h00;
			pa_nxt    = 2'h0;
			pb_nxt    = 1'b0;
			accw_nxt  = 3'h0;
			accr_nxt  = accel_pkg::acc_last_byte;
			zcnt_nxt  = 3'h0;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_r <= st_idle;
			dir_r   <= accel_pkg::ctl0_rst[accel_pkg::dir_bit];
			circ_r  <= accel_pkg::ctl0_rst[accel_pkg::circ_bit];
			cen_r   <= accel_pkg::ctl0_rst[accel_pkg::cen_bit];
			cnt_r   <= accel_pkg::ctl0_rst[4:0];
			busy_r  <= 1'b0;
			ovf_r   <= 1'b0;
			carry_r <= 1'b0;
			opa_r   <= accel_pkg::opa_rst;
			opb_r   <= accel_pkg::opb_rst;
			acc_r   <= accel_pkg::acc_rst;
			pa_r    <= 2'h0;
			pb_r    <= 1'b0;
			accw_r  <= 3'h0;
			accr_r  <= accel_pkg::acc_last_byte;
			zcnt_r  <= 3'h0;
			steps_r <= 5'h00;
			rdata_r <= accel_pkg::rdata_rst;
		end
		else
		begin
			state_r <= state_nxt;
			dir_r   <= dir_nxt;
			circ_r  <= circ_nxt;
			cen_r   <= cen_nxt;
			cnt_r   <= cnt_nxt;
			busy_r  <= busy_nxt;
			ovf_r   <= ovf_nxt;
			carry_r <= carry_nxt;
			opa_r   <= opa_nxt;
			opb_r   <= opb_nxt;
			acc_r   <= acc_nxt;
			pa_r    <= pa_nxt;
			pb_r    <= pb_nxt;
			accw_r  <= accw_nxt;
			accr_r  <= accr_nxt;
			zcnt_r  <= zcnt_nxt;
			steps_r <= steps_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign sfr_rdata = rdata_r;
endmodule

// ### dv/accel_checker_props.sv
// Concurrent checks on the accelerator register port, bound to arith_accel.
// Assumes control registers are written and read back only while the accelerator is idle.
`timescale 1ns/1ns
module accel_checker
(
	input wire logic       clk,
	input wire logic       srst,
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata
);
	// ==========================================================
	// Helper state
	logic       fresh_r;
	logic       fresh_nxt;
	logic [7:0] wlast_r;
	logic [7:0] wlast_nxt;
	always_comb
	begin
		fresh_nxt = srst | (fresh_r & ~sfr_wr);
		wlast_nxt = sfr_wr ? sfr_wdata : wlast_r;
	end
	always_ff @(posedge clk)
	begin
		fresh_r <= fresh_nxt;
		wlast_r <= wlast_nxt;
	end
	// ==========================================================
	// Sequences and assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	sequence s_rd_c0;
		sfr_rd && sfr_addr == accel_pkg::ctl0_addr;
	endsequence
	sequence s_rd_c1;
		sfr_rd && sfr_addr == accel_pkg::ctl1_addr;
	endsequence
	sequence s_rd_acc;
		sfr_rd && sfr_addr == accel_pkg::acc_addr;
	endsequence
	sequence s_load;
		sfr_wr && (sfr_addr == accel_pkg::opa_addr || sfr_addr == accel_pkg::opb_addr);
	endsequence
	sequence s_zero;
		sfr_wr && sfr_addr == accel_pkg::acc_addr && sfr_wdata == 8'h00;
	endsequence
	AST_RDATA_HOLD: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("Read data changed without a read.");
	AST_FRESH_CTL0: assert property (fresh_r && sfr_rd && sfr_addr == accel_pkg::ctl0_addr |=> sfr_rdata == 8'h00)
		else $error("Control zero not clear after reset.");
	AST_FRESH_CTL1: assert property (fresh_r && sfr_rd && sfr_addr == accel_pkg::ctl1_addr |=> sfr_rdata == 8'h0F)
		else $error("Control one not idle after reset.");
	AST_FRESH_ACC: assert property (fresh_r && sfr_rd && sfr_addr == accel_pkg::acc_addr |=> sfr_rdata == 8'h00)
		else $error("Accumulator not clear after reset.");
	AST_CLEAR_READS_ZERO: assert property (s_rd_c1 |=> sfr_rdata[4:0] == 5'h0F)
		else $error("Clear command bit or reserved bits read wrong.");
	AST_BUSY_ON_LOAD: assert property (s_load ##1 s_rd_c1 |=> sfr_rdata[accel_pkg::busy_bit])
		else $error("Busy not set after an operand write.");
	AST_CLEAR_ACC: assert property (sfr_wr && sfr_addr == accel_pkg::ctl1_addr && sfr_wdata[4] ##1 s_rd_acc |=> sfr_rdata == 8'h00)
		else $error("Accumulator not clear after clear command.");
	AST_ZERO_WRITES: assert property (s_zero [*5] ##1 s_rd_acc |=> sfr_rdata == 8'h00)
		else $error("Five zero writes did not clear the accumulator.");
	AST_CARRY_WRITE: assert property (sfr_wr && sfr_addr == accel_pkg::ctl1_addr ##1 s_rd_c1 |=> sfr_rdata[5] == wlast_r[5])
		else $error("Stored carry does not follow its write.");
	AST_CTL0_ECHO: assert property (sfr_wr && sfr_addr == accel_pkg::ctl0_addr ##1 s_rd_c0 |=> sfr_rdata == wlast_r)
		else $error("Control zero does not read back.");
endmodule
bind arith_accel accel_checker u_chk (.clk(clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
	.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));

// ### dv/core_bus_model.sv
// Processor core model driving the register bus with byte-sequenced tasks.
// Tasks are entered at a rising edge and return at one; writes keep the strobe up to run back to back.
`timescale 1ns/1ns
module core_bus_model
(
	input  wire logic       clk,
	input  wire logic [7:0] sfr_rdata,
	output logic      [7:0] sfr_addr,
	output logic            sfr_wr,
	output logic            sfr_rd,
	output logic      [7:0] sfr_wdata
);
	initial
	begin
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		#1;
		sfr_rd = 1'b0;
		sfr_wr = 1'b1;
		sfr_addr = a;
		sfr_wdata = d;
		@(posedge clk);
	endtask
	// Write data is scrambled on reads so a stale byte is never mistaken for a fresh one.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		#1;
		sfr_wr = 1'b0;
		sfr_rd = 1'b1;
		sfr_addr = a;
		sfr_wdata = ~sfr_wdata;
		@(posedge clk);
		#1;
		sfr_rd = 1'b0;
		d = sfr_rdata;
		@(posedge clk);
	endtask
	task automatic idle(input int n);
		#1;
		sfr_wr = 1'b0;
		repeat (n) @(posedge clk);
	endtask
	task automatic wr_opa(input logic [31:0] v);
		for (int i = 0; i < 4; i++) wr(accel_pkg::opa_addr, v[8*i +: 8]);
	endtask
	task automatic rd_opa(output logic [31:0] v);
		for (int i = 0; i < 4; i++) rd(accel_pkg::opa_addr, v[8*i +: 8]);
	endtask
	task automatic wr_acc(input logic [39:0] v, input int n);
		for (int i = 0; i < n; i++) wr(accel_pkg::acc_addr, v[8*i +: 8]);
	endtask
	task automatic rd_acc(output logic [39:0] v);
		for (int i = 4; i >= 0; i--) rd(accel_pkg::acc_addr, v[8*i +: 8]);
	endtask
endmodule

// ### dv/testbench.sv
// Self-checking bench for arith_accel: table of operations, then reset, clear and abort cases.
// Assumes the core model and bound checker from this folder.
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
	typedef struct packed
	{
		logic [1:0]  op;
		logic [7:0]  c0;
		logic        c;
		logic [31:0] a;
		logic [15:0] b;
		logic [31:0] ea;
		logic        ec;
		logic        ov;
		logic [4:0]  cnt;
	} row_t;
	logic        clk;
	logic        srst;
	logic [7:0]  sfr_addr;
	logic        sfr_wr;
	logic        sfr_rd;
	logic [7:0]  sfr_wdata;
	logic [7:0]  sfr_rdata;
	logic [7:0]  d;
	logic [31:0] a;
	logic [39:0] acc;
	int          error_cnt = 0;
	int          checks = 0;
	// Columns: op, control zero, carry in, A, B, expected A, carry, overflow, count.
	localparam row_t rows [13] = '{
		'{2'h0, 8'h00, 1'h0, 32'h00000102, 16'h0003, 32'h00000306, 1'h0, 1'h0, 5'h00},
		'{2'h0, 8'h00, 1'h1, 32'h00001234, 16'h0010, 32'h00012340, 1'h1, 1'h1, 5'h00},
		'{2'h1, 8'h00, 1'h0, 32'h00000064, 16'h0007, 32'h0000000E, 1'h0, 1'h0, 5'h00},
		'{2'h1, 8'h00, 1'h0, 32'h00000005, 16'h0000, 32'hFFFFFFFF, 1'h0, 1'h1, 5'h00},
		'{2'h2, 8'h01, 1'h1, 32'h80000001, 16'h0000, 32'h00000002, 1'h1, 1'h0, 5'h01},
		'{2'h2, 8'h9E, 1'h0, 32'h80000001, 16'h0000, 32'h00000002, 1'h0, 1'h0, 5'h1E},
		'{2'h2, 8'h41, 1'h1, 32'h80000001, 16'h0000, 32'h00000003, 1'h1, 1'h0, 5'h01},
		'{2'h2, 8'hC1, 1'h1, 32'h80000001, 16'h0000, 32'hC0000000, 1'h1, 1'h0, 5'h01},
		'{2'h2, 8'h21, 1'h0, 32'h80000001, 16'h0000, 32'h00000002, 1'h1, 1'h0, 5'h01},
		'{2'h2, 8'hA1, 1'h0, 32'h80000001, 16'h0000, 32'h40000000, 1'h1, 1'h0, 5'h01},
		'{2'h2, 8'h24, 1'h1, 32'h80000001, 16'h0000, 32'h0000001C, 1'h0, 1'h0, 5'h04},
		'{2'h2, 8'h00, 1'h1, 32'h00001000, 16'h0000, 32'h80000000, 1'h1, 1'h0, 5'h13},
		'{2'h2, 8'h00, 1'h0, 32'h00000001, 16'h0000, 32'h80000000, 1'h0, 1'h0, 5'h1F}};
	arith_accel dut (.clk(clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
	core_bus_model cpu (.clk(clk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata));
	initial clk = 1'b0;
	always #5 clk = ~clk;
	// ==========================================================
	// Operation helpers
	task automatic start(input logic [31:0] va, input logic [15:0] vb, input logic [1:0] op);
		cpu.wr_opa(va);
		cpu.wr(accel_pkg::opb_addr, vb[7:0]);
		cpu.wr(accel_pkg::opb_addr, vb[15:8]);
		cpu.rd(accel_pkg::ctl1_addr, d);
		`CHK(d[7], 1'b1)
		cpu.wr(accel_pkg::cmd_addr, {6'h00, op});
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		d = 8'hFF;
		while (d[7] !== 1'b0 && n < 60)
		begin
			cpu.rd(accel_pkg::ctl1_addr, d);
			n++;
		end
		`CHK(d[7], 1'b0)
	endtask
	task automatic do_row(input row_t r);
		cpu.wr(accel_pkg::opa_addr, 8'h00);
		cpu.wr(accel_pkg::ctl1_addr, {2'b00, r.c, 5'h10});
		cpu.wr(accel_pkg::ctl0_addr, r.c0);
		start(r.a, r.b, r.op);
		wait_idle();
		cpu.rd_opa(a);
		`CHK(a, r.ea)
		cpu.rd(accel_pkg::ctl1_addr, d);
		`CHK(d[6:5], {r.ov, r.ec})
		cpu.rd(accel_pkg::ctl0_addr, d);
		`CHK(d, {r.c0[7:5], r.cnt})
		cpu.rd_acc(acc);
		`CHK(acc, (r.op == accel_pkg::op_shift) ? 40'h0000000000 : {8'h00, r.ea})
	endtask
	task automatic final_report();
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		#400000;
		error_cnt++;
		final_report();
	end
	// ==========================================================
	// Main sequence
	initial
	begin
		srst = 1'b1;
		repeat (10) @(posedge clk);
		#1 srst = 1'b0;
		@(posedge clk);
		cpu.rd(accel_pkg::ctl0_addr, d);
		`CHK(d, 8'h00)
		cpu.rd(accel_pkg::ctl1_addr, d);
		`CHK(d, 8'h0F)
		cpu.rd_acc(acc);
		`CHK(acc, 40'h0000000000)
		cpu.wr(accel_pkg::ctl0_addr, 8'hA5);
		cpu.rd(accel_pkg::ctl0_addr, d);
		`CHK(d, 8'hA5)
		cpu.wr(accel_pkg::ctl1_addr, 8'h30);
		cpu.rd(accel_pkg::ctl1_addr, d);
		`CHK(d, 8'h2F)
		foreach (rows[i]) do_row(rows[i]);
		// Multiply and divide results pile up in the accumulator until something clears it.
		cpu.wr(accel_pkg::ctl0_addr, 8'h00);
		start(32'h00000102, 16'h0003, accel_pkg::op_mul);
		wait_idle();
		start(32'h00000064, 16'h0007, accel_pkg::op_div);
		wait_idle();
		cpu.wr(accel_pkg::ctl0_addr, 8'h01);
		start(32'h00000001, 16'h0000, accel_pkg::op_shift);
		wait_idle();
		cpu.rd_acc(acc);
		`CHK(acc, 40'h0000000314)
		cpu.wr(accel_pkg::ctl1_addr, 8'h10);
		cpu.wr_acc(40'h0000001234, 2);
		cpu.rd_acc(acc);
		`CHK(acc, 40'h0000001234)
		// The write pointer now sits mid-word; five zero writes must clear and rewind it.
		cpu.wr_acc(40'h0000000000, 5);
		cpu.rd_acc(acc);
		`CHK(acc, 40'h0000000000)
		cpu.wr_acc(40'h123456789A, 5);
		cpu.rd_acc(acc);
		`CHK(acc, 40'h123456789A)
		cpu.wr_acc(40'h00000000FF, 1);
		cpu.wr_opa(32'hDEADBEEF);
		cpu.wr(accel_pkg::ctl1_addr, 8'h10);
		cpu.rd_acc(acc);
		`CHK(acc, 40'h0000000000)
		cpu.rd_opa(a);
		`CHK(a, 32'h00000000)
		cpu.wr(accel_pkg::ctl0_addr, 8'h1F);
		start(32'h00000001, 16'h0000, accel_pkg::op_shift);
		cpu.idle(3);
		cpu.wr(accel_pkg::ctl1_addr, 8'h00);
		cpu.rd(accel_pkg::ctl1_addr, d);
		`CHK(d, 8'h0F)
		cpu.rd(accel_pkg::ctl0_addr, d);
		`CHK(d, 8'h00)
		start(32'h00000005, 16'h0003, accel_pkg::op_mul);
		wait_idle();
		cpu.rd_opa(a);
		`CHK(a, 32'h0000000F)
		cpu.wr(accel_pkg::ctl1_addr, 8'h20);
		cpu.idle(1);
		#1 srst = 1'b1;
		repeat (2) @(posedge clk);
		#1 srst = 1'b0;
		@(posedge clk);
		cpu.rd(accel_pkg::ctl1_addr, d);
		`CHK(d, 8'h0F)
		cpu.rd_acc(acc);
		`CHK(acc, 40'h0000000000)
		final_report();
	end
endmodule
